// ===== rtl/fpu_exc_pkg.sv
package fpu_exc_pkg;

  // Exception flag layout, shared by the flag bank and the mask input.
  localparam int unsigned EXC_W    = 6;
  localparam int unsigned EXC_IE   = 0;
  localparam int unsigned EXC_DE   = 1;
  localparam int unsigned EXC_ZE   = 2;
  localparam int unsigned EXC_OE   = 3;
  localparam int unsigned EXC_UE   = 4;
  localparam int unsigned EXC_PE   = 5;
  // The stack-fault flag sits just above the six exception flags.
  localparam int unsigned FLAG_STK = 6;
  localparam int unsigned FLAG_W   = 7;

  localparam int unsigned IP_W     = 32;
  localparam int unsigned OPC_W    = 11;
  localparam int unsigned OPND_W   = 32;

  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;
  localparam logic [EXC_W-1:0]  EXC_NONE  = 6'h00;
  localparam logic [IP_W-1:0]   IP_RST    = 32'h00000000;
  localparam logic [OPC_W-1:0]  OPC_RST   = 11'h000;
  localparam logic [OPND_W-1:0] OPND_RST  = 32'h00000000;

  // Kind of the instruction the core is about to execute.
  typedef enum logic [1:0] {
    INSTR_INT,
    INSTR_FP_WAIT,
    INSTR_FP_NOWAIT,
    INSTR_WAIT
  } instr_kind_e;

  // Operations that clear or overwrite the sticky flags.
  typedef enum logic [2:0] {
    CLR_NONE,
    CLR_CLEX,
    CLR_INIT,
    CLR_SAVE,
    CLR_RESTORE,
    CLR_LDENV
  } clr_op_e;

  typedef enum logic {
    ST_RUN,
    ST_FROZEN
  } freeze_state_e;

  typedef struct packed {
    instr_kind_e       kind;
    logic [IP_W-1:0]   ip;
    logic [OPC_W-1:0]  opcode;
    logic [OPND_W-1:0] opnd;
  } instr_s;

  typedef struct packed {
    logic [IP_W-1:0]   ip;
    logic [OPC_W-1:0]  opcode;
    logic [OPND_W-1:0] opnd;
  } ctx_s;

  localparam ctx_s CTX_RST = '{ip: IP_RST, opcode: OPC_RST, opnd: OPND_RST};

endpackage

// ===== rtl/fpu_exception_sync.sv
// Contract
// [RULE1] Each numeric instruction captures pointer, opcode and operand context on start.
// [RULE2] Exceptions whose mask bit is set get a default fix-up, no handler.
// [RULE3] An unmasked exception aborts the instruction and stays pending for a handler.
// [RULE4] Push to full or pop from empty sets stack fault and invalid-operation.
// [RULE5] A pending unmasked exception freezes before the next wait or FP instruction.
// [RULE6] The ignore-numeric-error input suppresses that freeze; execution continues.
// [RULE7] No-wait FP instructions never freeze, even with an exception pending.
// [RULE8] The handler is invoked before the next wait or FP instruction executes.
// [RULE9] Handler invocation may fall anywhere between detection and that instruction.
// [RULE10] Integer instructions run alongside FP work and never wait on it.
// [RULE11] A wait forces servicing of any pending exception before later code.
// [RULE12] Flags are sticky; only clear, init, save, restore or load-environment clear them.
// [RULE13] The error output starts external handler invocation, here at detection.
// [RULE14] With native mode off and ignore active, the pending exception is disregarded.
// [RULE15] Pending holds while any unmasked flag is set and returns on reload.
`timescale 1ns/1ns
module fpu_exception_sync
  import fpu_exc_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Instruction offered by the core
  input  wire logic              instr_valid_i,
  input  wire instr_s            instr_i,
  output logic                   instr_freeze_o,
  // Exception report from the arithmetic datapath
  input  wire logic              exc_valid_i,
  input  wire logic [EXC_W-1:0]  exc_flags_i,
  input  wire logic              stack_fault_i,
  output logic                   fixup_o,
  output logic                   abort_o,
  // Control word and flag maintenance
  input  wire logic [EXC_W-1:0]  exc_mask_i,
  input  wire clr_op_e           clr_op_i,
  input  wire logic [FLAG_W-1:0] load_flags_i,
  // Error reporting mode and pins
  input  wire logic              native_error_mode_bit_i,
  input  wire logic              ignore_numeric_error_in_i,
  output logic                   fp_error_out_o,
  output logic                   handler_req_o,
  // Visible state
  output logic [FLAG_W-1:0]      flags_o,
  output logic                   stack_fault_flag_o,
  output logic                   exc_pending_o,
  output ctx_s                   ctx_o
);

  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] flag_set;
  logic [EXC_W-1:0]  exc_eff;
  logic              flag_clr;
  logic              flag_load;
  logic              ignore_sync;
  logic              ignore_eff;
  logic              pending;
  logic              sync_point;
  logic              freeze;
  logic              accept;
  logic              unmasked_hit;
  logic              masked_only;

  ctx_s              ctx_r;
  logic              fixup_r;
  logic              abort_r;
  logic              fp_error_r;
  logic              handler_req_r;
  freeze_state_e     state_r;
  freeze_state_e     state_nxt;

  // The ignore pin comes from board logic and is not tied to this clock.
  level_sync2 u_ignore_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (ignore_numeric_error_in_i),
    .sync_o    (ignore_sync)
  );

  // [RULE4] stack fault implies invalid
  always_comb
  begin
    exc_eff = EXC_NONE;
    if (exc_valid_i)
      exc_eff = exc_flags_i;
    if (stack_fault_i)
      exc_eff[EXC_IE] = 1'b1;
  end

  assign flag_set = {stack_fault_i, exc_eff};

  // [RULE12] only these operations clear
  assign flag_clr  = (clr_op_i == CLR_CLEX) || (clr_op_i == CLR_INIT) ||
                     (clr_op_i == CLR_SAVE);
  assign flag_load = (clr_op_i == CLR_RESTORE) || (clr_op_i == CLR_LDENV);

  generate
    for (genvar g = 0; g < FLAG_W; g++)
    begin : g_flag
      sticky_flag u_flag (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .set_i      (flag_set[g]),
        .clr_i      (flag_clr),
        .load_i     (flag_load),
        .load_val_i (load_flags_i[g]),
        .flag_o     (flags[g])
      );
    end
  endgenerate

  // [RULE15] pending follows unmasked flags
  assign pending = |(flags[EXC_W-1:0] & ~exc_mask_i);

  // [RULE14] ignore honoured only outside native mode
  assign ignore_eff = ignore_sync && !native_error_mode_bit_i;

  // [RULE10] integer and no-wait never sync
  assign sync_point = (instr_i.kind == INSTR_WAIT) || (instr_i.kind == INSTR_FP_WAIT);

  // [RULE5] freeze before wait or FP instruction
  // [RULE6] ignore input lifts the freeze outside native mode
  // [RULE7] no-wait forms pass
  // [RULE11] wait forces servicing first
  assign freeze = instr_valid_i && sync_point && pending && !ignore_eff;
  assign accept = instr_valid_i && !freeze;

  assign unmasked_hit = |(exc_eff & ~exc_mask_i);
  assign masked_only  = (|exc_eff) && !unmasked_hit;

  // [RULE1] context captured at instruction start
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ctx_r <= CTX_RST;
    else if (accept && (instr_i.kind == INSTR_FP_WAIT || instr_i.kind == INSTR_FP_NOWAIT))
      ctx_r <= '{ip: instr_i.ip, opcode: instr_i.opcode, opnd: instr_i.opnd};
  end

  // [RULE2] masked default fix-up
  // [RULE3] unmasked aborts the instruction
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fixup_r <= 1'b0;
      abort_r <= 1'b0;
    end
    else
    begin
      fixup_r <= masked_only;
      abort_r <= unmasked_hit;
    end
  end

  // [RULE13] error output raised at detection
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      fp_error_r <= 1'b0;
    else
      fp_error_r <= pending && !native_error_mode_bit_i;
  end

  // Native mode has no external path, so the freeze itself asks for the handler.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (freeze)
          state_nxt = ST_FROZEN;
      ST_FROZEN:
        if (!freeze)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // [RULE8] native mode: handler requested once as the freeze begins
  // [RULE9] request lands inside the interval
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      handler_req_r <= 1'b0;
    else
      handler_req_r <= (state_r == ST_RUN) && freeze && native_error_mode_bit_i;
  end

  assign instr_freeze_o     = freeze;
  assign fixup_o            = fixup_r;
  assign abort_o            = abort_r;
  assign fp_error_out_o     = fp_error_r;
  assign handler_req_o      = handler_req_r;
  assign flags_o            = flags;
  assign stack_fault_flag_o = flags[FLAG_STK];
  assign exc_pending_o      = pending;
  assign ctx_o              = ctx_r;

  AST_CTX_CAPTURE: assert property ( // [RULE1]
    @(posedge sys_clk_i) disable iff (rst_i)
    accept && instr_i.kind == INSTR_FP_WAIT |=> ctx_o.ip == $past(instr_i.ip)
      && ctx_o.opnd == $past(instr_i.opnd))
    else $error("Context not captured at numeric instruction start.");

  AST_MASKED_FIXUP: assert property ( // [RULE2]
    @(posedge sys_clk_i) disable iff (rst_i)
    exc_valid_i && !stack_fault_i && exc_flags_i != EXC_NONE
      && (exc_flags_i & ~exc_mask_i) == EXC_NONE |=> fixup_o && !abort_o)
    else $error("Masked exception did not take the default fix-up.");

  AST_UNMASKED_ABORT: assert property ( // [RULE3]
    @(posedge sys_clk_i) disable iff (rst_i)
    exc_valid_i && (exc_flags_i & ~exc_mask_i) != EXC_NONE && clr_op_i == CLR_NONE
      ##1 $stable(exc_mask_i) |-> abort_o && exc_pending_o && !fixup_o)
    else $error("Unmasked exception did not abort and stay pending.");

  AST_STACK_FAULT: assert property ( // [RULE4]
    @(posedge sys_clk_i) disable iff (rst_i)
    stack_fault_i |=> stack_fault_flag_o && flags_o[EXC_IE])
    else $error("Stack fault did not set stack fault and invalid flags.");

  AST_FREEZE: assert property ( // [RULE5]
    @(posedge sys_clk_i) disable iff (rst_i)
    instr_valid_i && instr_i.kind == INSTR_WAIT && exc_pending_o
      && !ignore_numeric_error_in_i [*3] |-> instr_freeze_o)
    else $error("Wait executed with an unmasked exception pending.");

  AST_IGNORE: assert property ( // [RULE6]
    @(posedge sys_clk_i) disable iff (rst_i)
    !native_error_mode_bit_i && ignore_numeric_error_in_i [*3] |-> !instr_freeze_o)
    else $error("Freeze held although ignore input is active.");

  AST_NOWAIT: assert property ( // [RULE7]
    @(posedge sys_clk_i) disable iff (rst_i)
    instr_valid_i && instr_i.kind == INSTR_FP_NOWAIT |-> !instr_freeze_o)
    else $error("No-wait instruction was frozen.");

  AST_INTEGER: assert property ( // [RULE10]
    @(posedge sys_clk_i) disable iff (rst_i)
    instr_valid_i && instr_i.kind == INSTR_INT |-> !instr_freeze_o)
    else $error("Integer instruction was held.");

  AST_STICKY: assert property ( // [RULE12]
    @(posedge sys_clk_i) disable iff (rst_i)
    flags_o[EXC_ZE] && clr_op_i == CLR_NONE |=> flags_o[EXC_ZE])
    else $error("Sticky flag dropped without a clearing operation.");

  AST_ERROR_OUT: assert property ( // [RULE13]
    @(posedge sys_clk_i) disable iff (rst_i)
    exc_pending_o && !native_error_mode_bit_i [*2] |-> fp_error_out_o)
    else $error("Error output not raised for a pending exception.");

  AST_NATIVE_REQ: assert property ( // [RULE8]
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(instr_freeze_o) && native_error_mode_bit_i |=> handler_req_o)
    else $error("Frozen in native mode without a handler request.");

  AST_RELOAD: assert property ( // [RULE15]
    @(posedge sys_clk_i) disable iff (rst_i)
    clr_op_i == CLR_LDENV && (load_flags_i[EXC_W-1:0] & ~exc_mask_i) != EXC_NONE
      ##1 $stable(exc_mask_i) |-> exc_pending_o)
    else $error("Reloaded unmasked flag did not re-raise pending.");

  AST_CTX_NOWAIT: assert property ( // [RULE1]
    @(posedge sys_clk_i) disable iff (rst_i)
    accept && instr_i.kind == INSTR_FP_NOWAIT |=> ctx_o.opcode == $past(instr_i.opcode))
    else $error("No-wait instruction context not captured.");

  AST_FIXUP_IDLE: assert property ( // [RULE2]
    @(posedge sys_clk_i) disable iff (rst_i)
    !exc_valid_i && !stack_fault_i |=> !fixup_o && !abort_o)
    else $error("Fix-up or abort raised without an exception report.");

  AST_FREEZE_NATIVE: assert property ( // [RULE14]
    @(posedge sys_clk_i) disable iff (rst_i)
    instr_valid_i && instr_i.kind == INSTR_FP_WAIT && exc_pending_o
      && native_error_mode_bit_i |-> instr_freeze_o)
    else $error("Numeric instruction ran in native mode with an exception pending.");

  AST_HANDLER_PULSE: assert property ( // [RULE8]
    @(posedge sys_clk_i) disable iff (rst_i)
    handler_req_o |=> !handler_req_o)
    else $error("Handler request held for more than one cycle.");

  AST_ERROR_DROP: assert property ( // [RULE13]
    @(posedge sys_clk_i) disable iff (rst_i)
    !exc_pending_o |=> !fp_error_out_o)
    else $error("Error output raised with no exception pending.");

  AST_CLEAR: assert property ( // [RULE12]
    @(posedge sys_clk_i) disable iff (rst_i)
    (clr_op_i == CLR_CLEX || clr_op_i == CLR_INIT || clr_op_i == CLR_SAVE)
      && !exc_valid_i && !stack_fault_i |=> flags_o == FLAGS_RST)
    else $error("Clearing operation left a flag set.");

  AST_LOAD: assert property ( // [RULE15]
    @(posedge sys_clk_i) disable iff (rst_i)
    (clr_op_i == CLR_RESTORE || clr_op_i == CLR_LDENV) && !exc_valid_i && !stack_fault_i
      |=> flags_o == $past(load_flags_i))
    else $error("Reload did not place the given flags.");

endmodule

// ===== rtl/level_sync2.sv
`timescale 1ns/1ns
module level_sync2
  import fpu_exc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Level crossing
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// ===== rtl/sticky_flag.sv
`timescale 1ns/1ns
module sticky_flag
  import fpu_exc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Flag control
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic load_i,
  input  wire logic load_val_i,
  output logic      flag_o
);

  logic flag_r;
  logic flag_nxt;

  // A hardware set in the same cycle as a clear or reload is never lost.
  always_comb
  begin
    flag_nxt = flag_r;
    if (load_i)
      flag_nxt = load_val_i;
    else if (clr_i)
      flag_nxt = 1'b0;
    if (set_i)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag_o = flag_r;

endmodule

// ===== test/core_model.sv
`timescale 1ns/1ns
module core_model
  import fpu_exc_pkg::*;
(
  // Clock and reset
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  // Request from the bench
  input  wire logic   start_i,
  input  wire instr_s req_i,
  // Offer to the unit
  input  wire logic   freeze_i,
  output logic        valid_o,
  output instr_s      instr_o,
  output logic        done_o
);
  assign done_o = valid_o & ~freeze_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      valid_o <= 1'b0;
      instr_o <= '0;
    end
    else if (start_i)
    begin
      valid_o <= 1'b1;
      instr_o <= req_i;
    end
    else if (done_o)
    begin
      valid_o <= 1'b0;
      // A released offer must not keep showing stale fields.
      instr_o <= ~instr_o;
    end
  end
endmodule

// ===== test/fpu_exception_sync_tb.sv
`timescale 1ns/1ns
module fpu_exception_sync_tb;
  import fpu_exc_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic             start = 1'b0;
  logic             exc_valid = 1'b0;
  logic             stack_fault = 1'b0;
  logic             native = 1'b0;
  logic             ignore = 1'b0;
  logic [EXC_W-1:0] exc_flags = EXC_NONE;
  logic [EXC_W-1:0] exc_mask = 6'h3F;
  clr_op_e          clr_op = CLR_NONE;
  logic [FLAG_W-1:0] load_flags = FLAGS_RST;
  instr_s           req = '0;
  instr_s           instr;
  logic             valid, freeze, done, fixup, abort, fp_err, hreq, sff, pend;
  logic [FLAG_W-1:0] flags;
  ctx_s             ctx;
  int               miscompares = 0;
  int               check_count = 0;

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  core_model u_core_model (.sys_clk_i(sys_clk), .rst_i(rst), .start_i(start), .req_i(req),
    .freeze_i(freeze), .valid_o(valid), .instr_o(instr), .done_o(done));

  fpu_exception_sync u_fpu_exception_sync (.sys_clk_i(sys_clk), .rst_i(rst),
    .instr_valid_i(valid), .instr_i(instr), .instr_freeze_o(freeze),
    .exc_valid_i(exc_valid), .exc_flags_i(exc_flags), .stack_fault_i(stack_fault),
    .fixup_o(fixup), .abort_o(abort), .exc_mask_i(exc_mask), .clr_op_i(clr_op),
    .load_flags_i(load_flags), .native_error_mode_bit_i(native),
    .ignore_numeric_error_in_i(ignore), .fp_error_out_o(fp_err), .handler_req_o(hreq),
    .flags_o(flags), .stack_fault_flag_o(sff), .exc_pending_o(pend), .ctx_o(ctx));

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic offer(input instr_kind_e k, input logic [IP_W-1:0] ip);
    @(posedge sys_clk);
    start <= 1'b1;
    req <= '{kind: k, ip: ip, opcode: ip[OPC_W-1:0], opnd: ~ip};
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
  endtask

  // Leaves one edge past the accept so registered context has landed.
  task automatic taken(input int n, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < n && !ok; i++)
    begin
      ok = (done === 1'b1);
      cyc(1);
    end
  endtask

  task automatic raise(input logic [EXC_W-1:0] m, input logic [EXC_W-1:0] f, input logic s);
    @(posedge sys_clk);
    exc_mask <= m;
    exc_valid <= ~s;
    stack_fault <= s;
    exc_flags <= f;
    @(posedge sys_clk);
    exc_valid <= 1'b0;
    stack_fault <= 1'b0;
    #1;
  endtask

  task automatic clear(input clr_op_e op, input logic [FLAG_W-1:0] v);
    @(posedge sys_clk);
    clr_op <= op;
    load_flags <= v;
    @(posedge sys_clk);
    clr_op <= CLR_NONE;
    #1;
  endtask

  task automatic t_ctx();
    logic ok;
    chk(flags === FLAGS_RST && ctx === CTX_RST && fp_err === 1'b0, "reset state");
    offer(INSTR_FP_WAIT, 32'h1234ABCD);
    taken(3, ok);
    chk(ok, "fp instr not taken");
    chk(ctx.ip === 32'h1234ABCD && ctx.opcode === 11'h3CD && ctx.opnd === 32'hEDCB5432,
      "context");
  endtask

  task automatic t_masked();
    logic ok;
    raise(6'h3F, 6'h04, 1'b0);
    chk(fixup === 1'b1 && abort === 1'b0 && pend === 1'b0, "masked fixup");
    cyc(1);
    chk(fixup === 1'b0 && flags === 7'h04, "fixup pulse or flag");
    offer(INSTR_WAIT, 32'h00000010);
    taken(2, ok);
    chk(ok, "wait frozen when masked");
    raise(6'h3F, 6'h20, 1'b0);
    chk(flags === 7'h24, "sticky accumulate");
    clear(CLR_CLEX, 7'h00);
    chk(flags === 7'h00, "clear exceptions");
  endtask

  task automatic t_unmasked();
    logic ok;
    raise(6'h3B, 6'h04, 1'b0);
    chk(abort === 1'b1 && fixup === 1'b0 && pend === 1'b1, "unmasked abort");
    cyc(1);
    chk(fp_err === 1'b1, "error out at detection");
    offer(INSTR_INT, 32'h00000020);
    taken(1, ok);
    chk(ok, "integer waited");
    offer(INSTR_FP_NOWAIT, 32'h00000030);
    taken(1, ok);
    chk(ok, "no-wait froze");
    offer(INSTR_WAIT, 32'h00000040);
    cyc(4);
    chk(freeze === 1'b1 && done === 1'b0, "wait not frozen");
    clear(CLR_CLEX, 7'h00);
    taken(2, ok);
    chk(ok, "wait not released");
    chk(fp_err === 1'b0 && pend === 1'b0, "pending stuck");
  endtask

  task automatic t_stack();
    raise(6'h3E, 6'h00, 1'b1);
    chk(flags === 7'h41 && sff === 1'b1 && abort === 1'b1, "stack fault");
    clear(CLR_INIT, 7'h00);
    chk(flags === 7'h00 && sff === 1'b0, "init clear");
  endtask

  task automatic t_ignore();
    logic ok;
    @(posedge sys_clk);
    ignore <= 1'b1;
    raise(6'h3E, 6'h01, 1'b0);
    cyc(1);
    offer(INSTR_FP_WAIT, 32'h00000050);
    taken(2, ok);
    chk(ok, "ignore did not suppress freeze");
    @(posedge sys_clk);
    native <= 1'b1;
    offer(INSTR_FP_WAIT, 32'h00000060);
    cyc(1);
    chk(hreq === 1'b1 && fp_err === 1'b0, "native handler request");
    cyc(2);
    chk(freeze === 1'b1, "native mode ignored freeze");
    clear(CLR_SAVE, 7'h00);
    taken(2, ok);
    chk(ok && flags === 7'h00, "save clear");
    @(posedge sys_clk);
    ignore <= 1'b0;
    native <= 1'b0;
  endtask

  task automatic t_reload();
    clear(CLR_LDENV, 7'h01);
    chk(flags === 7'h01 && pend === 1'b1, "reload unmasked");
    clear(CLR_RESTORE, 7'h02);
    chk(flags === 7'h02 && pend === 1'b0, "reload masked");
    clear(CLR_CLEX, 7'h00);
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(3);
    t_ctx();
    t_masked();
    t_unmasked();
    t_stack();
    t_ignore();
    t_reload();
    final_report();
  end

  // The whole sequence needs under a hundred cycles.
  initial
  begin
    #20000;
    miscompares++;
    final_report();
  end
endmodule
